// ---- lbc_pkg.sv ----
// shared types and constants for the local bus cycle controller
package lbc_pkg;

  // ****************************************
  // timing and widths
  // ****************************************
  localparam int LBC_TEST_LOW_CYC = 5;
  localparam int LBC_FIFO_DEPTH = 4;
  localparam logic [2:0] LBC_TEST_CNT_W1 = 3'h5;

  // ****************************************
  // cycle status codes, also the request kind
  // ****************************************
  typedef enum logic [2:0] {
    LBC_CYC_INTERRUPT_ACK_STROBE = 3'h0,
    LBC_CYC_IO_RD = 3'h1,
    LBC_CYC_IO_WR = 3'h2,
    LBC_CYC_HALT = 3'h3,
    LBC_CYC_FETCH = 3'h4,
    LBC_CYC_MEM_RD = 3'h5,
    LBC_CYC_MEM_WR = 3'h6,
    LBC_CYC_PASSIVE = 3'h7
  } lbc_cyc_e;

  // ****************************************
  // bus sequencer states
  // ****************************************
  typedef enum logic [8:0] {
    LBC_ST_IDLE = 9'h001,
    LBC_ST_T1 = 9'h002,
    LBC_ST_T2 = 9'h004,
    LBC_ST_T3 = 9'h008,
    LBC_ST_TW = 9'h010,
    LBC_ST_T4 = 9'h020,
    LBC_ST_HALTED = 9'h040,
    LBC_ST_TSTWAIT = 9'h080,
    LBC_ST_HOLD = 9'h100
  } lbc_state_e;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    lbc_cyc_e kind;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic high_byte_enable_b;
    logic last_of_instr;
  } lbc_req_s;

  typedef struct packed {
    logic [15:0] ad_o;
    logic ad_oe_b;
    logic [3:0] a_hi_o;
    logic ctl_oe_b;
    logic high_byte_enable_b;
    logic ale;
    logic rd_b;
    logic wr_b;
    logic interrupt_ack_strobe_b;
    logic m_io;
    logic transceiver_direction;
    logic transceiver_enable_b;
    lbc_cyc_e cycle_status_code;
    logic lock_b;
    logic hold_ack;
  } lbc_pins_s;

  localparam lbc_pins_s LBC_PINS_RST = '{
    ad_o: 16'h0000, ad_oe_b: 1'b1, a_hi_o: 4'h0, ctl_oe_b: 1'b0,
    high_byte_enable_b: 1'b1, ale: 1'b0, rd_b: 1'b1, wr_b: 1'b1,
    interrupt_ack_strobe_b: 1'b1, m_io: 1'b0, transceiver_direction: 1'b1,
    transceiver_enable_b: 1'b1, cycle_status_code: LBC_CYC_PASSIVE,
    lock_b: 1'b1, hold_ack: 1'b0};

endpackage

// ---- lbc_bus_ctrl.sv ----
// request fifo and local bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// request fifo
// ****************************************
module lbc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lbc_fifo_s;
  lbc_fifo_s f_r, f_nxt;
  logic push, pop;
  // full only when every slot holds a word
  assign in_ready = f_r.cnt < (AW+1)'(D);
  assign out_valid = f_r.cnt != '0;
  assign out_data = f_r.mem[f_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    f_nxt = f_r;
    if (push) begin
      f_nxt.mem[f_r.wp] = in_data;
      f_nxt.wp = (f_r.wp == AW'(D - 1)) ? '0 : f_r.wp + 1'b1;
    end
    if (pop) begin
      f_nxt.rp = (f_r.rp == AW'(D - 1)) ? '0 : f_r.rp + 1'b1;
    end
    f_nxt.cnt = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      f_r <= '0;
    end else if (clk_en) begin
      f_r <= f_nxt;
    end
  end
endmodule // lbc_fifo

// ****************************************
// bus cycle sequencer
// ****************************************
// Contract
// - minimum mode halt gives one address strobe and no control strobe
// - maximum mode halt drives halt code on cycle status outputs
// - hold while halted keeps halt and reissues the halt indication after
// - halt is left only by interrupt request or reset
// - lock output goes low the cycle after the lock prefix decode
// - lock released at end of last bus cycle of the locked instruction
// - hold request during lock is held off and granted after release if still asserted
// - wait with test high suspends, idles, runs no bus cycles until low
// - hold while waiting on test floats all bus drivers
// - interrupt while waiting refetches wait and services the interrupt
// - strap high drives own strobes, strap low emits cycle status
// - every cycle starts in the first state, with an address strobe in minimum mode only
// - memory versus io select valid from first through fourth state
// - read floats the bus and asserts read in the second state
// - minimum mode drives transceiver direction and enable
// - write data driven from second state through the fourth
// - write strobe from second state through third and wait states
// - high byte enable and low address bit select the byte lanes
// - interrupt ack is two back to back cycles, type times four
// - maximum mode status encodes cycle type, strobes left to controller
// - status codes 000 ack to 111 passive as tabled
// - cycles take four states, wait states between third and fourth
module lbc_bus_ctrl (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // bus requests from the execution side
  input wire logic req_valid,
  output logic req_ready,
  input wire lbc_pkg::lbc_req_s req_data,
  // execution side controls
  input wire logic lock_prefix_decoded,
  input wire logic wait_cmd,
  input wire logic int_enabled,
  // execution side answers
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [9:0] vector_addr,
  output logic vector_valid,
  output logic wait_done,
  output logic wait_refetch,
  output logic halted,
  // pins from outside
  input wire logic mode_strap,
  input wire logic ready,
  input wire logic test_b,
  input wire logic intr,
  input wire logic hold_req,
  input wire logic [15:0] ad_i,
  // pins to outside
  output lbc_pkg::lbc_pins_s pins
);
  import lbc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0] strap_sy;
    logic [1:0] ready_sy;
    logic [1:0] test_sy;
    logic [1:0] intr_sy;
    logic [1:0] hold_sy;
    logic [1:0][15:0] ad_sy;
    lbc_state_e st;
    lbc_req_s cur;
    logic interrupt_ack_strobe_second;
    logic lock;
    logic ret_halt;
    logic ret_wait;
    logic [2:0] test_cnt;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic vector_valid;
    logic [9:0] vector_addr;
    logic wait_done;
    logic wait_refetch;
    lbc_pins_s pins;
  } lbc_top_s;
  lbc_top_s s_r, s_nxt;
  logic fifo_valid;
  logic fifo_pop;
  lbc_req_s fifo_data;
  logic mn, rdy_s, test_s, intr_s, hold_s, rd, wr, ia;
  assign mn = s_r.strap_sy[1];
  assign rdy_s = s_r.ready_sy[1];
  assign test_s = s_r.test_sy[1];
  assign intr_s = s_r.intr_sy[1];
  assign hold_s = s_r.hold_sy[1];
  lbc_fifo #(.W($bits(lbc_req_s)), .D(LBC_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );
  // ****************************************
  // lane helpers
  // ****************************************
  function automatic logic [15:0] lbc_lane_rd(input logic bhe_b, input logic a0, input logic [15:0] bus);
    unique case ({bhe_b, a0})
      2'b00: lbc_lane_rd = bus;
      2'b01: lbc_lane_rd = {8'h00, bus[15:8]};
      2'b10: lbc_lane_rd = {8'h00, bus[7:0]};
      default: lbc_lane_rd = 16'h0000;
    endcase
  endfunction
  function automatic logic [15:0] lbc_lane_wr(input logic bhe_b, input logic a0, input logic [15:0] d);
    unique case ({bhe_b, a0})
      2'b01: lbc_lane_wr = {d[7:0], 8'h00};
      default: lbc_lane_wr = d;
    endcase
  endfunction
  function automatic logic lbc_is_read(input lbc_cyc_e k);
    lbc_is_read = (k == LBC_CYC_IO_RD) || (k == LBC_CYC_FETCH) || (k == LBC_CYC_MEM_RD);
  endfunction
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    lbc_state_e st_nx;
    s_nxt = s_r;
    st_nx = s_r.st;
    fifo_pop = 1'b0;
    s_nxt.strap_sy = {s_r.strap_sy[0], mode_strap};
    s_nxt.ready_sy = {s_r.ready_sy[0], ready};
    s_nxt.test_sy = {s_r.test_sy[0], test_b};
    s_nxt.intr_sy = {s_r.intr_sy[0], intr};
    s_nxt.hold_sy = {s_r.hold_sy[0], hold_req};
    s_nxt.ad_sy = {s_r.ad_sy[0], ad_i};
    s_nxt.rsp_valid = 1'b0;
    s_nxt.vector_valid = 1'b0;
    s_nxt.wait_done = 1'b0;
    s_nxt.wait_refetch = 1'b0;
    if (lock_prefix_decoded) begin
      s_nxt.lock = 1'b1;
    end
    unique case (s_r.st)
      LBC_ST_IDLE: begin
        if (hold_s && !s_r.lock) begin
          st_nx = LBC_ST_HOLD;
        end else if (wait_cmd) begin
          if (test_s) begin
            st_nx = LBC_ST_TSTWAIT;
            s_nxt.test_cnt = '0;
          end else begin
            s_nxt.wait_done = 1'b1;
          end
        end else if (fifo_valid) begin
          fifo_pop = 1'b1;
          s_nxt.cur = fifo_data;
          s_nxt.interrupt_ack_strobe_second = 1'b0;
          st_nx = LBC_ST_T1;
        end
      end
      LBC_ST_T1: begin
        st_nx = (s_r.cur.kind == LBC_CYC_HALT) ? LBC_ST_HALTED : LBC_ST_T2;
      end
      LBC_ST_T2: st_nx = LBC_ST_T3;
      LBC_ST_T3, LBC_ST_TW: begin
        if (rdy_s) begin
          st_nx = LBC_ST_T4;
          s_nxt.rsp_data = lbc_lane_rd(s_r.cur.high_byte_enable_b, s_r.cur.addr[0], s_r.ad_sy[1]);
          s_nxt.vector_addr = {s_r.ad_sy[1][7:0], 2'b00};
        end else begin
          st_nx = LBC_ST_TW;
        end
      end
      LBC_ST_T4: begin
        st_nx = LBC_ST_IDLE;
        if (s_r.cur.kind == LBC_CYC_INTERRUPT_ACK_STROBE) begin
          if (!s_r.interrupt_ack_strobe_second) begin
            s_nxt.interrupt_ack_strobe_second = 1'b1;
            st_nx = LBC_ST_T1;
          end else begin
            s_nxt.vector_valid = 1'b1;
          end
        end else if (lbc_is_read(s_r.cur.kind)) begin
          s_nxt.rsp_valid = 1'b1;
        end
        if (s_r.cur.last_of_instr && !lock_prefix_decoded) begin
          s_nxt.lock = 1'b0;
        end
      end
      LBC_ST_HALTED: begin
        if (intr_s) begin
          st_nx = LBC_ST_IDLE;
        end else if (hold_s && !s_r.lock) begin
          st_nx = LBC_ST_HOLD;
          s_nxt.ret_halt = 1'b1;
        end
      end
      LBC_ST_TSTWAIT: begin
        s_nxt.test_cnt = test_s ? '0 : s_r.test_cnt + 3'h1;
        if (!test_s && s_r.test_cnt == LBC_TEST_CNT_W1 - 3'h1) begin
          st_nx = LBC_ST_IDLE;
          s_nxt.wait_done = 1'b1;
        end else if (intr_s && int_enabled) begin
          st_nx = LBC_ST_IDLE;
          s_nxt.wait_refetch = 1'b1;
        end else if (hold_s && !s_r.lock) begin
          st_nx = LBC_ST_HOLD;
          s_nxt.ret_wait = 1'b1;
        end
      end
      LBC_ST_HOLD: begin
        if (!hold_s) begin
          s_nxt.ret_halt = 1'b0;
          s_nxt.ret_wait = 1'b0;
          if (s_r.ret_halt) begin
            st_nx = LBC_ST_T1;
          end else if (s_r.ret_wait) begin
            st_nx = LBC_ST_TSTWAIT;
            s_nxt.test_cnt = '0;
          end else begin
            st_nx = LBC_ST_IDLE;
          end
        end
      end
    endcase
    s_nxt.st = st_nx;

    // pins follow the state being entered
    rd = lbc_is_read(s_nxt.cur.kind);
    wr = (s_nxt.cur.kind == LBC_CYC_IO_WR) || (s_nxt.cur.kind == LBC_CYC_MEM_WR);
    ia = s_nxt.cur.kind == LBC_CYC_INTERRUPT_ACK_STROBE;
    s_nxt.pins = LBC_PINS_RST;
    s_nxt.pins.lock_b = !s_nxt.lock;
    s_nxt.pins.m_io = s_r.pins.m_io;
    if (st_nx inside {LBC_ST_T1, LBC_ST_T2, LBC_ST_T3, LBC_ST_TW, LBC_ST_T4}) begin
      s_nxt.pins.m_io = s_nxt.cur.kind[2];
      s_nxt.pins.high_byte_enable_b = s_nxt.cur.high_byte_enable_b;
      s_nxt.pins.a_hi_o = s_nxt.cur.addr[19:16];
      s_nxt.pins.transceiver_direction = !(rd || ia);
    end
    unique case (st_nx)
      LBC_ST_T1: begin
        s_nxt.pins.ale = mn;
        s_nxt.pins.ad_o = s_nxt.cur.addr[15:0];
        s_nxt.pins.ad_oe_b = ia;
        s_nxt.pins.cycle_status_code = mn ? LBC_CYC_PASSIVE : s_nxt.cur.kind;
      end
      LBC_ST_T2: begin
        s_nxt.pins.cycle_status_code = mn ? LBC_CYC_PASSIVE : s_nxt.cur.kind;
        s_nxt.pins.transceiver_enable_b = !mn;
        s_nxt.pins.rd_b = !(mn && rd);
        s_nxt.pins.interrupt_ack_strobe_b = !(mn && ia);
        s_nxt.pins.wr_b = !(mn && wr);
        s_nxt.pins.ad_oe_b = !wr;
        s_nxt.pins.ad_o = lbc_lane_wr(s_nxt.cur.high_byte_enable_b, s_nxt.cur.addr[0], s_nxt.cur.wdata);
      end
      LBC_ST_T3, LBC_ST_TW: begin
        s_nxt.pins.transceiver_enable_b = !mn;
        s_nxt.pins.rd_b = !(mn && rd);
        s_nxt.pins.interrupt_ack_strobe_b = !(mn && ia);
        s_nxt.pins.wr_b = !(mn && wr);
        s_nxt.pins.ad_oe_b = !wr;
        s_nxt.pins.ad_o = s_r.pins.ad_o;
      end
      LBC_ST_T4: begin
        s_nxt.pins.transceiver_enable_b = !mn;
        s_nxt.pins.ad_oe_b = !wr;
        s_nxt.pins.ad_o = s_r.pins.ad_o;
      end
      LBC_ST_HOLD: begin
        s_nxt.pins.ctl_oe_b = 1'b1;
        s_nxt.pins.hold_ack = 1'b1;
      end
      default: ;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.st <= LBC_ST_IDLE;
      s_r.pins <= LBC_PINS_RST;
      s_r.cur.kind <= LBC_CYC_PASSIVE;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign pins = s_r.pins;
  assign rsp_valid = s_r.rsp_valid;
  assign rsp_data = s_r.rsp_data;
  assign vector_valid = s_r.vector_valid;
  assign vector_addr = s_r.vector_addr;
  assign wait_done = s_r.wait_done;
  assign wait_refetch = s_r.wait_refetch;
  // still halted through a hold and the reissued halt cycle
  assign halted = (s_r.st == LBC_ST_HALTED) || s_r.ret_halt || (s_r.st == LBC_ST_T1 && s_r.cur.kind == LBC_CYC_HALT);
  // ****************************************
  // checks
  // ****************************************
  sequence lbc_pfx_seq;
    lock_prefix_decoded && clk_en;
  endsequence
  sequence lbc_lock_low_seq;
    !pins.lock_b;
  endsequence

  lock_after_prefix_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    lbc_pfx_seq |=> lbc_lock_low_seq) else $error("lock not low after prefix");
  halt_min_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_b || !clk_en)
    (s_r.st == LBC_ST_T1 && s_r.cur.kind == LBC_CYC_HALT && mn) |-> pins.ale && pins.rd_b && pins.wr_b
    && pins.interrupt_ack_strobe_b) else $error("halt strobes wrong");
  halt_code_max_a: assert property (@(posedge sys_clk) disable iff (!rst_b || !clk_en)
    (s_r.st == LBC_ST_T1 && s_r.cur.kind == LBC_CYC_HALT && !mn) |-> pins.cycle_status_code == LBC_CYC_HALT
    && !pins.ale) else $error("halt code missing");
  halt_stays_a: assert property (@(posedge sys_clk) disable iff (!rst_b || !clk_en)
    (halted && !intr_s && !hold_s) |=> halted) else $error("halt left without cause");
  grant_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_r.lock && s_r.st != LBC_ST_HOLD) |=> !pins.hold_ack) else $error("grant during lock");
  hold_float_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    pins.hold_ack |-> pins.ctl_oe_b && pins.ad_oe_b) else $error("drivers on in hold");
  wait_no_bus_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_r.st == LBC_ST_TSTWAIT) |-> !pins.ale && pins.rd_b && pins.wr_b) else $error("bus cycle while waiting");
  read_float_a: assert property (@(posedge sys_clk) disable iff (!rst_b || !clk_en)
    (s_r.st == LBC_ST_T2 && lbc_is_read(s_r.cur.kind)) |-> pins.ad_oe_b && (pins.rd_b != mn))
    else $error("read phase wrong");
  write_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_b || !clk_en)
    (s_r.st inside {LBC_ST_T2, LBC_ST_T3, LBC_ST_TW} && s_r.cur.kind == LBC_CYC_MEM_WR && mn)
    |-> !pins.wr_b && !pins.ad_oe_b) else $error("write strobe wrong");
  wait_state_a: assert property (@(posedge sys_clk) disable iff (!rst_b || !clk_en)
    (s_r.st inside {LBC_ST_T3, LBC_ST_TW} && !rdy_s) |=> s_r.st == LBC_ST_TW) else $error("no wait state");
endmodule // lbc_bus_ctrl

`default_nettype wire

// ---- lbc_far_model.sv ----
// far side model: latches, memory and io devices, interrupt controller
`timescale 1ns/1ps
`default_nettype none
module lbc_far_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // bench controls
  input wire logic mode_strap,
  input wire logic [1:0] wait_n,
  input wire logic [7:0] vec_type,
  // local bus
  input wire lbc_pkg::lbc_pins_s pins,
  output logic ready,
  output logic [15:0] ad_i
);
  import lbc_pkg::*;
  logic [15:0] mem [16];
  logic [15:0] wbuf, last;
  logic [3:0] ix;
  logic [2:0] cnt;
  logic bhe_b, a0, wr_seen;
  // released bus toggles so a stale value never reads as data
  always_comb begin
    if (!pins.ad_oe_b) ad_i = pins.ad_o;
    else if (!pins.interrupt_ack_strobe_b) ad_i = {~last[15:8], vec_type};
    else if (!pins.rd_b) ad_i = mem[ix];
    else ad_i = ~last;
  end
  always_ff @(posedge sys_clk) begin
    last <= ad_i;
    if (!rst_b) begin
      ready <= 1'b0;
      wr_seen <= 1'b0;
      cnt <= 3'h0;
      for (int j = 0; j < 16; j++) mem[j] <= 16'h0000;
    end else begin
      if (pins.ale) begin
        ix <= {pins.m_io, pins.ad_o[3:1]};
        bhe_b <= pins.high_byte_enable_b;
        a0 <= pins.ad_o[0];
      end
      if (!mode_strap) ready <= 1'b1;
      else if (pins.rd_b && pins.wr_b && pins.interrupt_ack_strobe_b) begin
        ready <= 1'b0;
        cnt <= 3'h0;
      end else begin
        if (cnt != 3'h7) cnt <= cnt + 3'h1;
        ready <= cnt >= {1'b0, wait_n};
      end
      if (!pins.wr_b && !pins.ad_oe_b) begin
        wbuf <= pins.ad_o;
        wr_seen <= 1'b1;
      end else if (wr_seen) begin
        wr_seen <= 1'b0;
        if (!bhe_b) mem[ix][15:8] <= wbuf[15:8];
        if (!a0) mem[ix][7:0] <= wbuf[7:0];
      end
    end
  end
endmodule // lbc_far_model
`default_nettype wire

// ---- lbc_bus_ctrl_tb.sv ----
// self-checking bench for the local bus cycle controller
`timescale 1ns/1ps
`default_nettype none
module lbc_bus_ctrl_tb;
  import lbc_pkg::*;
  // ********
  // signals
  // ********
  logic sys_clk, rst_b, req_valid, req_ready, lock_prefix_decoded, wait_cmd, int_enabled;
  logic rsp_valid, vector_valid, wait_done, wait_refetch, halted;
  logic mode_strap, ready, test_b, intr, hold_req, maxm, seen, p_ale, p_rd, p_wr, p_ack;
  logic [15:0] rsp_data, ad_i;
  logic [15:0] sh [16];
  logic [9:0] vector_addr;
  logic [1:0] wait_n;
  logic [7:0] vec_type;
  lbc_req_s req_data;
  lbc_pins_s pins;
  lbc_cyc_e code;
  int err_total, num_checks, cyc, ale_n, stb_n, ack_n, done_n, ref_n, i;
  lbc_bus_ctrl u_lbc_bus_ctrl (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .req_valid(req_valid),
    .req_ready(req_ready), .req_data(req_data), .lock_prefix_decoded(lock_prefix_decoded),
    .wait_cmd(wait_cmd), .int_enabled(int_enabled), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .vector_addr(vector_addr), .vector_valid(vector_valid), .wait_done(wait_done),
    .wait_refetch(wait_refetch), .halted(halted), .mode_strap(mode_strap), .ready(ready),
    .test_b(test_b), .intr(intr), .hold_req(hold_req), .ad_i(ad_i), .pins(pins));
  lbc_far_model u_lbc_far_model (.sys_clk(sys_clk), .rst_b(rst_b), .mode_strap(mode_strap),
    .wait_n(wait_n), .vec_type(vec_type), .pins(pins), .ready(ready), .ad_i(ad_i));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ********
  // helpers
  // ********
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // offers one request for up to tries cycles, keeps the shadow memory
  task automatic push(input lbc_cyc_e k, input logic [19:0] a, input logic [15:0] d, input logic bhe_b,
                      input logic last, input int tries, output bit ok);
    ok = 1'b0;
    @(posedge sys_clk);
    req_data <= '{kind: k, addr: a, wdata: d, high_byte_enable_b: bhe_b, last_of_instr: last};
    req_valid <= 1'b1;
    for (int n = 0; n < tries && !ok; n++) begin
      @(negedge sys_clk);
      ok = req_ready === 1'b1;
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    if (ok && !maxm && (k == LBC_CYC_MEM_WR || k == LBC_CYC_IO_WR)) begin
      case ({bhe_b, a[0]})
        2'b00: sh[{k[2], a[3:1]}] = d;
        2'b01: sh[{k[2], a[3:1]}][15:8] = d[7:0];
        2'b10: sh[{k[2], a[3:1]}][7:0] = d[7:0];
        default: ;
      endcase
    end
  endtask
  task automatic get_rsp(input logic [15:0] e, input logic [15:0] m);
    for (int n = 0; n < 200 && rsp_valid !== 1'b1; n++) @(negedge sys_clk);
    chk(rsp_valid === 1'b1 && (rsp_data & m) === e, "read data");
  endtask
  function automatic logic [15:0] exp_rd(input logic [15:0] w, input logic [1:0] ln);
    case (ln)
      2'b00: return w;
      2'b01: return {8'h00, w[15:8]};
      2'b10: return {8'h00, w[7:0]};
      default: return 16'h0000;
    endcase
  endfunction
  // ********
  // bus monitor
  // ********
  always @(negedge sys_clk) begin
    if (pins.ale === 1'b1 && p_ale !== 1'b1) ale_n++;
    if ((pins.rd_b === 1'b0 && p_rd === 1'b1) || (pins.wr_b === 1'b0 && p_wr === 1'b1)) stb_n++;
    if (pins.interrupt_ack_strobe_b === 1'b0 && p_ack === 1'b1) ack_n++;
    if (wait_done === 1'b1) done_n++;
    if (wait_refetch === 1'b1) ref_n++;
    if (pins.cycle_status_code !== LBC_CYC_PASSIVE && !seen) begin
      seen = 1'b1;
      code = pins.cycle_status_code;
    end
    if (pins.rd_b === 1'b0 || pins.interrupt_ack_strobe_b === 1'b0) chk(pins.ad_oe_b === 1'b1, "bus driven");
    if (!maxm && pins.rd_b === 1'b0)
      chk(pins.transceiver_direction === 1'b0 && pins.transceiver_enable_b === 1'b0, "transceiver");
    if (pins.wr_b === 1'b0) chk(pins.ad_oe_b === 1'b0, "write data");
    if (maxm)
      chk({pins.rd_b, pins.wr_b, pins.ale, pins.transceiver_enable_b} === 4'b1101, "max strobes");
    if (pins.lock_b === 1'b0) chk(pins.hold_ack !== 1'b1, "hold in lock");
    {p_ale, p_rd, p_wr, p_ack} = {pins.ale, pins.rd_b, pins.wr_b, pins.interrupt_ack_strobe_b};
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      $display("CHECK FAILED at %0t: run hung", $time);
      end_of_test;
    end
  end
  // ********
  // sequence
  // ********
  initial begin
    lbc_cyc_e k;
    lbc_cyc_e tbl [7];
    logic [19:0] a;
    logic [1:0] ln;
    bit ok;
    int n, b;
    tbl = '{LBC_CYC_INTERRUPT_ACK_STROBE, LBC_CYC_IO_RD, LBC_CYC_IO_WR, LBC_CYC_FETCH, LBC_CYC_MEM_RD, LBC_CYC_MEM_WR, LBC_CYC_HALT};
    void'($urandom(32'hbed5e00a));
    {rst_b, req_valid, lock_prefix_decoded, wait_cmd, int_enabled, intr, hold_req, maxm, seen} = '0;
    {mode_strap, test_b, wait_n, vec_type, req_data} = '0;
    {mode_strap, test_b} = 2'b11;
    {err_total, num_checks, cyc, ale_n, stb_n, ack_n, done_n, ref_n} = '0;
    foreach (sh[j]) sh[j] = 16'h0000;
    tick(3);
    rst_b <= 1'b1;
    tick(3);
    chk(pins.rd_b === 1'b1 && pins.lock_b === 1'b1 && pins.cycle_status_code === LBC_CYC_PASSIVE, "reset");
    for (int t = 0; t < 40; t++) begin
      ln = t < 4 ? 2'(t) : 2'($urandom_range(3));
      wait_n <= t < 4 ? 2'(t) : 2'($urandom_range(3));
      k = $urandom_range(1) ? LBC_CYC_MEM_WR : LBC_CYC_IO_WR;
      a = {k[2] ? 4'($urandom) : 4'h0, 15'($urandom), ln[0]};
      push(k, a, 16'($urandom), ln[1], 1'b0, 300, ok);
      push(k[2] ? LBC_CYC_MEM_RD : LBC_CYC_IO_RD, a, 16'h0, ln[1], 1'b0, 300, ok);
      get_rsp(exp_rd(sh[{k[2], a[3:1]}], ln), ^ln ? 16'h00ff : 16'hffff);
    end
    vec_type <= 8'($urandom);
    n = ack_n;
    push(LBC_CYC_INTERRUPT_ACK_STROBE, 20'h0, 16'h0, 1'b0, 1'b0, 300, ok);
    for (i = 0; i < 100 && vector_valid !== 1'b1; i++) @(negedge sys_clk);
    chk(vector_addr === {vec_type, 2'b00} && ack_n == n + 2, "vector");
    tick(10);
    n = ale_n;
    b = stb_n;
    push(LBC_CYC_HALT, 20'h0, 16'h0, 1'b1, 1'b0, 300, ok);
    for (i = 0; i < 50 && halted !== 1'b1; i++) @(negedge sys_clk);
    tick(4);
    chk(halted === 1'b1 && ale_n == n + 1 && stb_n == b, "halt entry");
    b = 0;
    repeat (6) begin
      push(LBC_CYC_MEM_WR, {16'h0, 3'($urandom), 1'b0}, 16'($urandom), 1'b0, 1'b0, 1, ok);
      b += ok;
    end
    chk(b == LBC_FIFO_DEPTH && halted === 1'b1 && ale_n == n + 1, "fifo while halted");
    hold_req <= 1'b1;
    for (i = 0; i < 50 && pins.hold_ack !== 1'b1; i++) @(negedge sys_clk);
    chk(pins.hold_ack === 1'b1 && pins.ctl_oe_b === 1'b1 && halted === 1'b1, "hold in halt");
    tick(1);
    hold_req <= 1'b0;
    tick(10);
    chk(ale_n == n + 2 && halted === 1'b1, "halt reissue");
    intr <= 1'b1;
    for (i = 0; i < 50 && halted !== 1'b0; i++) @(negedge sys_clk);
    chk(halted === 1'b0, "halt exit");
    tick(1);
    intr <= 1'b0;
    tick(60);
    lock_prefix_decoded <= 1'b1;
    tick(1);
    lock_prefix_decoded <= 1'b0;
    hold_req <= 1'b1;
    tick(2);
    chk(pins.lock_b === 1'b0, "lock set");
    push(LBC_CYC_MEM_WR, 20'h0000c, 16'h5aa5, 1'b0, 1'b0, 300, ok);
    push(LBC_CYC_MEM_RD, 20'h0000c, 16'h0, 1'b0, 1'b1, 300, ok);
    get_rsp(16'h5aa5, 16'hffff);
    for (i = 0; i < 10 && pins.lock_b !== 1'b1; i++) @(negedge sys_clk);
    chk(pins.lock_b === 1'b1, "lock release");
    for (i = 0; i < 20 && pins.hold_ack !== 1'b1; i++) @(negedge sys_clk);
    chk(pins.hold_ack === 1'b1, "held grant");
    tick(1);
    hold_req <= 1'b0;
    test_b <= 1'b1;
    tick(8);
    wait_cmd <= 1'b1;
    tick(1);
    wait_cmd <= 1'b0;
    n = ale_n;
    b = done_n;
    push(LBC_CYC_MEM_RD, 20'h00006, 16'h0, 1'b0, 1'b0, 300, ok);
    test_b <= 1'b0;
    tick(4);
    test_b <= 1'b1;
    hold_req <= 1'b1;
    for (i = 0; i < 50 && pins.hold_ack !== 1'b1; i++) @(negedge sys_clk);
    chk(pins.ad_oe_b === 1'b1 && pins.ctl_oe_b === 1'b1 && pins.hold_ack === 1'b1, "float");
    chk(done_n == b && ale_n == n, "early end");
    tick(1);
    hold_req <= 1'b0;
    tick(6);
    test_b <= 1'b0;
    get_rsp(sh[4'hb], 16'hffff);
    chk(done_n == b + 1, "wait done");
    tick(1);
    test_b <= 1'b1;
    int_enabled <= 1'b1;
    tick(4);
    wait_cmd <= 1'b1;
    tick(1);
    wait_cmd <= 1'b0;
    intr <= 1'b1;
    for (i = 0; i < 30 && ref_n == 0; i++) @(negedge sys_clk);
    chk(ref_n == 1, "refetch");
    tick(1);
    {intr, test_b, int_enabled} <= 3'b010;
    mode_strap <= 1'b0;
    tick(4);
    maxm = 1'b1;
    foreach (tbl[j]) begin
      seen = 1'b0;
      push(tbl[j], 20'h00010, 16'h1234, 1'b0, 1'b0, 300, ok);
      for (i = 0; i < 40 && !seen; i++) @(negedge sys_clk);
      chk(code === tbl[j], "status code");
      tick(20);
    end
    chk(halted === 1'b1, "max halt");
    end_of_test;
  end
endmodule // lbc_bus_ctrl_tb
`default_nettype wire
